/* File: src/bsp_defines.svh */
// Constants for the shared bus port block
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

`define BSP_OFF_UPPER_DATA  12'h000
`define BSP_OFF_LOWER_DATA  12'h004
`define BSP_OFF_UPPER_DIR   12'h008
`define BSP_OFF_LOWER_DIR   12'h00C
`define BSP_OFF_RSVD_FIRST  12'h010
`define BSP_OFF_RSVD_LAST   12'h01C
`define BSP_OFF_MODE        12'h020
`define BSP_OFF_STATUS      12'h024
`define BSP_ADDR_BITS       12
`define BSP_PORT_RESET      8'h00
`define BSP_DIR_RESET       8'h00
`define BSP_MODE_RESET      3'h0
`define BSP_MODE_WIDTH      3
`define BSP_HTRANS_NONSEQ   2'h2
`define BSP_HTRANS_SEQ      2'h3
`define BSP_HSIZE_WORD      3'h2

`endif

/* File: src/bsp_pkg.sv */
// Types for the shared bus port block
package bsp_pkg;
    typedef enum logic [2:0] {
        BSP_SINGLE_CHIP,
        BSP_EXP_NARROW,
        BSP_EXP_WIDE,
        BSP_EMU_NARROW,
        BSP_EMU_WIDE,
        BSP_PERIPHERAL
    } bsp_mode_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } bsp_pin_drive_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        addr_phase;
        logic        wide;
        logic        drive_data;
    } bsp_ext_bus_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bsp_echo_t;
endpackage

/* File: src/bsp_pin_sync.sv */
// Three-stage pin synchroniser, a change counted once stages two and three agree
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (clk_en) begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_level <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    pin_level[i] <= stage3[i];
                end
            end
        end
    end
endmodule

/* File: src/bsp_port_lane.sv */
// One 8-bit port lane: data and direction state, pin drive and read mux
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_port_lane #(
    parameter int WIDTH = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             clk_en,
    input  wire logic             gpio_mode,
    input  wire logic             data_we,
    input  wire logic             dir_we,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] pin_level,
    input  wire logic [WIDTH-1:0] bus_out,
    input  wire logic             bus_drive,
    output logic      [WIDTH-1:0] data_q,
    output logic      [WIDTH-1:0] dir_q,
    output logic      [WIDTH-1:0] read_value,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= `BSP_PORT_RESET;                        // [RQ14]
        end else if (clk_en && data_we) begin
            data_q <= wdata;                                  // [RQ9]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_q <= `BSP_DIR_RESET;                          // [RQ8]
        end else if (clk_en && dir_we) begin
            dir_q <= wdata;                                   // [RQ9]
        end
    end

    // Pin level for inputs, stored bit for outputs
    always_comb begin
        read_value = (dir_q & data_q) | (~dir_q & pin_level); // [RQ5]
    end

    // Bus function overrides direction bits outside GPIO use
    always_comb begin
        if (gpio_mode) begin
            pin_out  = data_q;                                // [RQ3]
            pin_oe_n = ~dir_q;                                // [RQ4] [RQ6]
        end else begin
            pin_out  = bus_out;                               // [RQ6]
            pin_oe_n = {WIDTH{~bus_drive}};
        end
    end
endmodule

/* File: src/bsp_port_ab.sv */
// Two shared address/data ports with AHB-Lite register access
//
// Operation
// (RQ1) Upper port carries A15..A8 and upper data
// (RQ2) Lower port carries A7..A0 and D7..D0
// (RQ3) Single chip: pins are general-purpose I/O
// (RQ4) Direction 1 drives, 0 is high-impedance input
// (RQ5) Read: pin level if input, register if output
// (RQ6) Direction bits apply only in GPIO use
// (RQ7) Expanded/peripheral: registers leave map, echoed out
// (RQ8) Direction registers reset to zero
// (RQ9) Registers read/write anytime while mapped
// (RQ10) Unused locations and bits read zero
// (RQ11) Reserved writes change nothing
// (RQ12) Peripheral mode: reserved locations unmapped
// (RQ13) Software waits one cycle after direction write
// (RQ14) Port data registers reset to zero
// (RQ15) Narrow: upper muxes address/data, lower address only; code does this in expanded narrow only, emulation narrow uses the wide mapping
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_port_ab (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  clk_en,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [15:0]           ext_addr,
    input  wire logic [15:0]           ext_wdata,
    input  wire logic                  ext_addr_phase,
    input  wire logic                  ext_drive_data,
    output logic      [15:0]           ext_rdata,
    input  wire logic [7:0]            upper_port_pin_in,
    output bsp_pkg::bsp_pin_drive_t    upper_port_drive,
    input  wire logic [7:0]            lower_port_pin_in,
    output bsp_pkg::bsp_pin_drive_t    lower_port_drive,
    output bsp_pkg::bsp_echo_t         echo,
    output bsp_pkg::bsp_mode_t         mode
);
    import bsp_pkg::*;

    logic                  req_valid;
    logic                  pend;
    logic                  pend_write;
    logic [`BSP_ADDR_BITS-1:0] pend_addr;
    logic                  in_map;
    logic [7:0]            upper_level;
    logic [7:0]            lower_level;
    logic [7:0]            upper_data;
    logic [7:0]            lower_data;
    logic [7:0]            upper_dir;
    logic [7:0]            lower_dir;
    logic [7:0]            upper_read;
    logic [7:0]            lower_read;
    logic [7:0]            upper_bus_out;
    logic [7:0]            lower_bus_out;
    logic                  upper_bus_drive;
    logic                  lower_bus_drive;
    logic                  gpio_mode;
    logic                  wr_now;
    logic [7:0]            wbyte;
    logic [31:0]           next_rdata;
    logic [7:0]            pin_sync_upper_level;

    // Port registers exist in the map only in single-chip operation
    function automatic logic regs_mapped(input bsp_mode_t m);
        return m == BSP_SINGLE_CHIP;                          // [RQ7]
    endfunction

    function automatic logic rsvd_hit(input logic [`BSP_ADDR_BITS-1:0] a);
        return a >= `BSP_OFF_RSVD_FIRST && a <= `BSP_OFF_RSVD_LAST;
    endfunction

    assign req_valid = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign gpio_mode = regs_mapped(mode);                     // [RQ3] [RQ6]
    assign wbyte     = hwdata[7:0];
    assign wr_now    = pend && pend_write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend       <= 1'b0;
            pend_write <= 1'b0;
            pend_addr  <= '0;
        end else if (clk_en) begin
            pend       <= req_valid;
            pend_write <= req_valid && hwrite;
            pend_addr  <= haddr[`BSP_ADDR_BITS-1:0];
        end
    end

    // Which locations answer on chip in the present mode
    always_comb begin
        unique case (pend_addr)
            `BSP_OFF_UPPER_DATA, `BSP_OFF_LOWER_DATA,
            `BSP_OFF_UPPER_DIR,  `BSP_OFF_LOWER_DIR: in_map = regs_mapped(mode); // [RQ7]
            default: in_map = rsvd_hit(pend_addr) ? (mode != BSP_PERIPHERAL) : 1'b1; // [RQ12]
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= bsp_mode_t'(`BSP_MODE_RESET);
        end else if (clk_en && wr_now && pend_addr == `BSP_OFF_MODE) begin
            if (hwdata[`BSP_MODE_WIDTH-1:0] <= BSP_PERIPHERAL) begin
                mode <= bsp_mode_t'(hwdata[`BSP_MODE_WIDTH-1:0]);
            end
        end
    end

    // Accesses to unmapped port locations are echoed to the external bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            echo <= '0;
        end else if (clk_en) begin
            echo.valid <= pend && !in_map;                    // [RQ7]
            echo.write <= pend_write;
            echo.addr  <= pend_addr[7:0];
            echo.wdata <= hwdata;
        end
    end

    bsp_pin_sync #(.WIDTH(8)) u_sync_upper (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .pin_in    (upper_port_pin_in),
        .pin_level (pin_sync_upper_level)
    );

    bsp_pin_sync #(.WIDTH(8)) u_sync_lower (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .pin_in    (lower_port_pin_in),
        .pin_level (lower_level)
    );

    assign upper_level = pin_sync_upper_level;

    // Bus function pin mapping
    always_comb begin
        upper_bus_out   = ext_addr[15:8];                     // [RQ1]
        lower_bus_out   = ext_addr[7:0];                      // [RQ2]
        upper_bus_drive = 1'b1;
        lower_bus_drive = 1'b1;
        unique case (mode)
            BSP_EXP_NARROW: begin
                // Upper carries address then the low data byte, ext_wdata[7:0]
                if (!ext_addr_phase) begin
                    upper_bus_out   = ext_wdata[7:0];         // [RQ15]
                    upper_bus_drive = ext_drive_data;
                end
            end
            BSP_SINGLE_CHIP: begin
                upper_bus_drive = 1'b0;
                lower_bus_drive = 1'b0;
            end
            default: begin
                if (!ext_addr_phase) begin
                    upper_bus_out   = ext_wdata[15:8];        // [RQ1]
                    lower_bus_out   = ext_wdata[7:0];         // [RQ2]
                    upper_bus_drive = ext_drive_data;
                    lower_bus_drive = ext_drive_data;
                end
            end
        endcase
    end

    // Lower port holds address only in expanded narrow mode
    assign ext_rdata = (mode == BSP_EXP_NARROW) ? {upper_level, upper_level}
                                                : {upper_level, lower_level}; // [RQ15]

    bsp_port_lane #(.WIDTH(8)) u_upper (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .gpio_mode  (gpio_mode),
        .data_we    (wr_now && in_map && pend_addr == `BSP_OFF_UPPER_DATA), // [RQ9]
        .dir_we     (wr_now && in_map && pend_addr == `BSP_OFF_UPPER_DIR),
        .wdata      (wbyte),
        .pin_level  (upper_level),
        .bus_out    (upper_bus_out),
        .bus_drive  (upper_bus_drive),
        .data_q     (upper_data),
        .dir_q      (upper_dir),
        .read_value (upper_read),
        .pin_out    (upper_port_drive.out),
        .pin_oe_n   (upper_port_drive.oe_n)
    );

    bsp_port_lane #(.WIDTH(8)) u_lower (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .gpio_mode  (gpio_mode),
        .data_we    (wr_now && in_map && pend_addr == `BSP_OFF_LOWER_DATA), // [RQ9]
        .dir_we     (wr_now && in_map && pend_addr == `BSP_OFF_LOWER_DIR),
        .wdata      (wbyte),
        .pin_level  (lower_level),
        .bus_out    (lower_bus_out),
        .bus_drive  (lower_bus_drive),
        .data_q     (lower_data),
        .dir_q      (lower_dir),
        .read_value (lower_read),
        .pin_out    (lower_port_drive.out),
        .pin_oe_n   (lower_port_drive.oe_n)
    );

    // Read data; reserved and unmapped words read zero, writes there do nothing
    always_comb begin
        next_rdata = '0;                                      // [RQ10] [RQ11]
        if (req_valid && !hwrite) begin
            unique case (haddr[`BSP_ADDR_BITS-1:0])
                `BSP_OFF_UPPER_DATA: next_rdata[7:0] = regs_mapped(mode) ? upper_read : 8'h00; // [RQ5]
                `BSP_OFF_LOWER_DATA: next_rdata[7:0] = regs_mapped(mode) ? lower_read : 8'h00;
                `BSP_OFF_UPPER_DIR:  next_rdata[7:0] = regs_mapped(mode) ? upper_dir : 8'h00;
                `BSP_OFF_LOWER_DIR:  next_rdata[7:0] = regs_mapped(mode) ? lower_dir : 8'h00;
                `BSP_OFF_MODE:       next_rdata[`BSP_MODE_WIDTH-1:0] = mode;
                `BSP_OFF_STATUS:     next_rdata[15:0] = {upper_level, lower_level};
                default:             next_rdata = '0;         // [RQ10]
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (clk_en) begin
            hrdata <= next_rdata;
        end
    end
endmodule

/* File: sim/bsp_port_ab_props.sv */
// Port-level checker for the bus-shared two-port block
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_port_ab_props (
    input logic                    hclk,
    input logic                    hresetn,
    input logic                    clk_en,
    input logic                    hsel,
    input logic [31:0]             haddr,
    input logic [1:0]              htrans,
    input logic                    hwrite,
    input logic                    hready,
    input logic [31:0]             hrdata,
    input logic                    hreadyout,
    input logic                    hresp,
    input logic [15:0]             ext_addr,
    input logic                    ext_addr_phase,
    input bsp_pkg::bsp_pin_drive_t upper_port_drive,
    input bsp_pkg::bsp_pin_drive_t lower_port_drive,
    input bsp_pkg::bsp_echo_t      echo,
    input bsp_pkg::bsp_mode_t      mode
);
    import bsp_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic taken;
    assign taken = hsel && hready && htrans[1] && clk_en;

    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("slave answer not ready or not okay");
    AST_DIR_RESET: assert property ($rose(hresetn) |-> {upper_port_drive.oe_n, lower_port_drive.oe_n} == 16'hFFFF)
        else $error("pins driven after reset");
    // Status word carries both synchronised pin bytes, so only bits above the low byte elsewhere
    AST_HI_ZERO: assert property (taken && !hwrite && haddr[11:0] != `BSP_OFF_STATUS |=> hrdata[31:8] == 24'h000000)
        else $error("unused read bits not zero");
    AST_RSVD_ZERO: assert property (taken && !hwrite && haddr[11:4] == 8'h01 |=> hrdata == 32'h00000000)
        else $error("reserved read not zero");
    AST_MAPPED: assert property (taken && mode == BSP_SINGLE_CHIP && haddr[11:4] == 8'h00 |-> ##1 !echo.valid ##1 !echo.valid)
        else $error("mapped access echoed");
    AST_UNMAPPED: assert property (taken && mode != BSP_SINGLE_CHIP && haddr[11:4] == 8'h00 |-> ##[1:2] echo.valid)
        else $error("unmapped port access not echoed");
    AST_PERIPH_RSVD: assert property (taken && mode == BSP_PERIPHERAL && haddr[11:4] == 8'h01 |-> ##[1:2] echo.valid)
        else $error("reserved access not echoed in peripheral mode");
    AST_ADDR_HI: assert property (mode == BSP_EXP_WIDE && ext_addr_phase |-> upper_port_drive == {ext_addr[15:8], 8'h00})
        else $error("upper port not carrying high address");
    AST_ADDR_LO: assert property (mode == BSP_EXP_WIDE && ext_addr_phase |-> lower_port_drive == {ext_addr[7:0], 8'h00})
        else $error("lower port not carrying low address");
endmodule

/* File: sim/bsp_pin_model.sv */
// Far-side pin model: resolves port drive against the outside level
`timescale 1ns/100ps
module bsp_pin_model (
    input  bsp_pkg::bsp_pin_drive_t drive,
    input  logic [7:0]              far_level,
    output logic [7:0]              pin_level
);
    import bsp_pkg::*;
    // Outside source wins only where the port is high impedance
    assign pin_level = (drive.oe_n & far_level) | (~drive.oe_n & drive.out);
endmodule

/* File: sim/test_bus_shared_port_ab_gpio.sv */
// Self-checking bench for the bus-shared two-port block
`timescale 1ns/100ps
`include "bsp_defines.svh"
module test_bus_shared_port_ab_gpio;
    import bsp_pkg::*;
    logic           hclk = 1'b0;
    logic           hresetn = 1'b0;
    logic [31:0]    haddr = 32'h0;
    logic [1:0]     htrans = 2'h0;
    logic           hwrite = 1'b0;
    logic [31:0]    hwdata = 32'h0;
    logic [15:0]    ext_addr = 16'h0;
    logic           ext_addr_phase = 1'b0;
    logic           clk_en = 1'b1;
    logic [15:0]    ext_wdata = 16'h0;
    logic           ext_drive_data = 1'b0;
    logic [15:0]    ext_rdata;
    bsp_echo_t      echo_q;
    bsp_mode_t      mode_q;
    logic [7:0]     up_far = 8'h5A;
    logic [7:0]     lo_far = 8'hC3;
    logic [7:0]     up_pin;
    logic [7:0]     lo_pin;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    bsp_pin_drive_t up_drv;
    bsp_pin_drive_t lo_drv;
    int             bad_count = 0;
    int             cmp_count = 0;
    int             cyc = 0;

    always #10 hclk = ~hclk;

    bsp_port_ab DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(`BSP_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_addr_phase(ext_addr_phase), .ext_drive_data(ext_drive_data), .ext_rdata(ext_rdata),
        .upper_port_pin_in(up_pin), .upper_port_drive(up_drv), .lower_port_pin_in(lo_pin),
        .lower_port_drive(lo_drv), .echo(echo_q), .mode(mode_q));
    bsp_pin_model u_up (.drive(up_drv), .far_level(up_far), .pin_level(up_pin));
    bsp_pin_model u_lo (.drive(lo_drv), .far_level(lo_far), .pin_level(lo_pin));

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= `BSP_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask

    task automatic t_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({16'h0, up_drv.oe_n, lo_drv.oe_n}, 32'h0000FFFF);
        rc(`BSP_OFF_UPPER_DIR, 32'h0);
        rc(`BSP_OFF_LOWER_DIR, 32'h0);
        wr(`BSP_OFF_UPPER_DIR, 32'hFF);
        wr(`BSP_OFF_LOWER_DIR, 32'hFF);
        // Outputs now show stored data, not the outside level
        repeat (1) @(posedge hclk);
        rc(`BSP_OFF_UPPER_DATA, 32'h0);
        rc(`BSP_OFF_LOWER_DATA, 32'h0);
    endtask

    task automatic t_gpio;
        logic [11:0] base;
        logic [7:0]  far;
        for (int p = 0; p < 2; p++) begin
            base = p ? `BSP_OFF_LOWER_DATA : `BSP_OFF_UPPER_DATA;
            far = p ? lo_far : up_far;
            wr(base, 32'hA5);
            wr(base + 12'h008, 32'h0F);
            // Pin path passes a three-stage synchroniser
            repeat (6) @(posedge hclk);
            rc(base, {24'h0, (8'hA5 & 8'h0F) | (far & 8'hF0)});
            rc(base + 12'h008, 32'h0F);
        end
        chk({8'h0, up_drv.out[3:0], up_drv.oe_n, lo_drv.out[3:0], lo_drv.oe_n}, 32'h005F05F0);
        up_far <= 8'h00;
        repeat (6) @(posedge hclk);
        rc(`BSP_OFF_UPPER_DATA, 32'h05);
        rc(`BSP_OFF_STATUS, 32'h000005C5);
    endtask

    task automatic t_rsvd;
        for (int a = 16; a <= 28; a += 4) begin
            wr(12'(a), 32'hFFFFFFFF);
            rc(12'(a), 32'h0);
        end
        // A write while the clock enable is low must leave no trace
        clk_en <= 1'b0;
        wr(`BSP_OFF_LOWER_DIR, 32'hFF);
        clk_en <= 1'b1;
        rc(`BSP_OFF_LOWER_DIR, 32'h0F);
        rc(`BSP_OFF_MODE, 32'h0);
    endtask

    task automatic t_mode;
        wr(`BSP_OFF_MODE, 32'h2);
        rc(`BSP_OFF_MODE, 32'h2);
        chk({29'h0, mode_q}, 32'h2);
        wr(`BSP_OFF_UPPER_DIR, 32'hFF);
        // Echo pulse stands for one cycle after the data phase
        @(negedge hclk);
        chk({14'h0, echo_q.valid, echo_q.write, echo_q.addr, echo_q.wdata[7:0]}, 32'h000308FF);
        rc(`BSP_OFF_UPPER_DATA, 32'h0);
        ext_addr <= 16'h1234;
        ext_addr_phase <= 1'b1;
        @(posedge hclk);
        chk({up_drv, lo_drv}, 32'h12003400);
        ext_addr_phase <= 1'b0;
        ext_wdata <= 16'hABCD;
        ext_drive_data <= 1'b1;
        @(posedge hclk);
        chk({up_drv, lo_drv}, 32'hAB00CD00);
        ext_drive_data <= 1'b0;
        up_far <= 8'h3C;
        repeat (6) @(posedge hclk);
        chk({16'h0, ext_rdata}, 32'h00003CC3);
        wr(`BSP_OFF_MODE, 32'h1);
        ext_drive_data <= 1'b1;
        @(posedge hclk);
        chk({up_drv, lo_drv}, 32'hCD003400);
        ext_drive_data <= 1'b0;
        // One-cycle data drive is filtered by the synchroniser
        @(posedge hclk);
        chk({16'h0, ext_rdata}, 32'h00003C3C);
        wr(`BSP_OFF_MODE, 32'h5);
        rc(`BSP_OFF_RSVD_FIRST, 32'h0);
        // Codes above the last mode leave the mode alone
        wr(`BSP_OFF_MODE, 32'h6);
        rc(`BSP_OFF_MODE, 32'h5);
        wr(`BSP_OFF_MODE, 32'h0);
        rc(`BSP_OFF_UPPER_DIR, 32'h0F);
    endtask

    initial begin
        t_reset();
        t_gpio();
        t_rsvd();
        t_mode();
        t_reset();
        end_sim();
    end
endmodule

bind bsp_port_ab bsp_port_ab_props u_props (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_addr(ext_addr), .ext_addr_phase(ext_addr_phase), .upper_port_drive(upper_port_drive),
    .lower_port_drive(lower_port_drive), .echo(echo), .mode(mode));
